// ===== stc_sysref_cal.sv
// Purpose: APB register file and control for SYSREF timing calibration.
// Assumes: sysref and APB inputs are synchronous to clk; reset_n is synchronous.
// Notes: Zero wait states; pready rises in the first access cycle.
//
// Implementation choice: the APB slave port.
`timescale 1ns/100ps

// Function
// - Enable low: output follows manual delay register
// - Enable high: calibration sets delay, manual ignored
// - Only a 0-to-1 enable change starts calibration
// - Averaging field bits 3-2 selects 4..256
// - Accumulation field bits 1-0 selects 4..256 cycles
// - Overlong SYSREF period makes calibration fail
// - Calibration ends within 256*19*4^(a+h+2) cycles
// - Done bit 17 reads 1 only enabled and finished
// - Status bits 16-0 return calibrated delay
// - Register decode at printed offsets with resets
// - Manual delay: invert 16, coarse 15-8, fine 7-0
// - Coarse manual field acts only while disabled
module stc_sysref_cal #(
    parameter int CAL_BOUND_BASE = stc_pkg::CAL_BOUND_AVG * stc_pkg::CAL_BOUND_STEP
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sysref,
    output logic [16:0] aperture_delay,
    output logic irq
);

    stc_cal_if cal ();

    logic sysref_cal_enable;
    logic [7:0] sysref_cal_config;
    logic [23:0] aperture_delay_adjust;
    logic [7:0] aperture_delay_ramp_ctrl;
    logic cal_complete_flag;
    logic [16:0] calibrated_delay_value;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [1:0] next_irq_status;
    logic setup;
    logic wr_en;
    logic mapped;
    logic [31:0] rd_mux;
    logic en_write;
    logic en_new;

    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready && pwrite && !pslverr;
    assign en_write = wr_en && paddr == stc_pkg::ADDR_ENABLE;
    assign en_new = pwdata[stc_pkg::ENABLE_BIT];

    // ************************************************************
    // Engine hookup
    // ************************************************************
    assign cal.start = en_write && en_new && !sysref_cal_enable;
    assign cal.abort = en_write && !en_new;
    assign cal.avg_code = sysref_cal_config[stc_pkg::AVG_LSB +: 2];
    assign cal.acc_code = sysref_cal_config[stc_pkg::ACC_LSB +: 2];
    assign cal.bound = 32'(CAL_BOUND_BASE) << (2 * (32'(cal.avg_code) + 32'(cal.acc_code)
                       + stc_pkg::CAL_BOUND_EXP_OFS));

    stc_cal_engine u_engine (
        .clk(clk),
        .reset_n(reset_n),
        .sysref(sysref),
        .cal(cal)
    );

    // ************************************************************
    // Writable registers
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sysref_cal_enable <= stc_pkg::ENABLE_RST[stc_pkg::ENABLE_BIT];
            sysref_cal_config <= stc_pkg::CONFIG_RST;
            aperture_delay_adjust <= stc_pkg::ADJUST_RST;
            aperture_delay_ramp_ctrl <= stc_pkg::RAMP_RST;
            irq_mask <= stc_pkg::IRQ_RST;
        end else if (wr_en) begin
            unique case (paddr)
                stc_pkg::ADDR_ENABLE: sysref_cal_enable <= en_new;
                stc_pkg::ADDR_CONFIG: sysref_cal_config <= pwdata[7:0];
                stc_pkg::ADDR_ADJUST: aperture_delay_adjust <= pwdata[23:0];
                stc_pkg::ADDR_RAMP: aperture_delay_ramp_ctrl <= pwdata[7:0];
                stc_pkg::ADDR_IRQ_MASK: irq_mask <= pwdata[1:0];
                default: begin
                end
            endcase
        end
    end

    // ************************************************************
    // Calibration result and done flag
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cal_complete_flag <= 1'b0;
            calibrated_delay_value <= 17'h00000;
        end else if (cal.start || cal.abort) begin
            cal_complete_flag <= 1'b0;
        end else if (cal.done && sysref_cal_enable) begin
            cal_complete_flag <= 1'b1;
            calibrated_delay_value <= cal.delay;
        end
    end

    // The output holds the last value while a calibration runs, so the clock never jumps mid-run.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            aperture_delay <= 17'h00000;
        end else if (!sysref_cal_enable) begin
            aperture_delay <= aperture_delay_adjust[stc_pkg::DELAY_W-1:0];
        end else if (cal.done) begin
            aperture_delay <= cal.delay;
        end
    end

    // ************************************************************
    // Interrupts
    // ************************************************************
    always_comb begin
        next_irq_status = irq_status;
        if (wr_en && paddr == stc_pkg::ADDR_IRQ_STATUS) begin
            next_irq_status = irq_status & ~pwdata[1:0];
        end
        next_irq_status[stc_pkg::IRQ_DONE_BIT] = next_irq_status[stc_pkg::IRQ_DONE_BIT]
                                                 | (cal.done && sysref_cal_enable);
        next_irq_status[stc_pkg::IRQ_FAIL_BIT] = next_irq_status[stc_pkg::IRQ_FAIL_BIT] | cal.fail;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            irq_status <= stc_pkg::IRQ_RST;
            irq <= 1'b0;
        end else begin
            irq_status <= next_irq_status;
            irq <= |(next_irq_status & irq_mask);
        end
    end

    // ************************************************************
    // APB read path
    // ************************************************************
    always_comb begin
        mapped = 1'b1;
        rd_mux = 32'h00000000;
        unique case (paddr)
            stc_pkg::ADDR_ENABLE: rd_mux = {31'h00000000, sysref_cal_enable};
            stc_pkg::ADDR_CONFIG: rd_mux = {24'h000000, sysref_cal_config};
            stc_pkg::ADDR_RESULT: begin
                rd_mux[stc_pkg::DONE_BIT] = cal_complete_flag && sysref_cal_enable;
                rd_mux[stc_pkg::DELAY_W-1:0] = calibrated_delay_value;
            end
            stc_pkg::ADDR_ADJUST: rd_mux = {8'h00, aperture_delay_adjust};
            stc_pkg::ADDR_RAMP: rd_mux = {24'h000000, aperture_delay_ramp_ctrl};
            stc_pkg::ADDR_IRQ_STATUS: rd_mux = {30'h00000000, irq_status};
            stc_pkg::ADDR_IRQ_MASK: rd_mux = {30'h00000000, irq_mask};
            default: mapped = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= setup;
            pslverr <= setup && !mapped;
            prdata <= (setup && !pwrite) ? rd_mux : 32'h00000000;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    chk_manual_follow: assert property (
        !sysref_cal_enable && $stable(aperture_delay_adjust) && $past(!sysref_cal_enable)
        |=> aperture_delay == $past(aperture_delay_adjust[16:0]))
        else $error("disabled output does not follow manual delay");
    chk_manual_ignored: assert property (
        sysref_cal_enable && !cal.done |=> $stable(aperture_delay))
        else $error("enabled output moved without a calibration result");
    chk_start_edge: assert property (
        cal.start |-> !sysref_cal_enable ##1 sysref_cal_enable)
        else $error("calibration started without a 0-to-1 enable change");
    chk_done_gated: assert property (
        cal_complete_flag && !sysref_cal_enable |-> rd_mux[stc_pkg::DONE_BIT] == 1'b0 || paddr != stc_pkg::ADDR_RESULT)
        else $error("done reads one while disabled");
    chk_result_held: assert property (
        cal.done && sysref_cal_enable |=> aperture_delay == calibrated_delay_value
        ##1 (sysref_cal_enable && !cal.done)[*2] |-> $stable(aperture_delay))
        else $error("calibrated delay not applied and held");
    chk_done_clears: assert property (
        cal.start || cal.abort |=> !cal_complete_flag)
        else $error("done flag survived a restart or disable");
    chk_config_reset: assert property (
        $rose(reset_n) |-> sysref_cal_config == stc_pkg::CONFIG_RST && !sysref_cal_enable)
        else $error("configuration or enable has wrong reset value");
    chk_irq_sticky: assert property (
        cal.fail |=> irq_status[stc_pkg::IRQ_FAIL_BIT] ##1 irq == irq_mask[stc_pkg::IRQ_FAIL_BIT] || irq)
        else $error("fail event lost from interrupt status");
    chk_pready_one: assert property (
        setup |=> pready ##1 !pready)
        else $error("pready is not a single cycle answer");
    cov_enable_done: cover property (cal.start ##[1:1000] cal_complete_flag);
    cov_irq: cover property ($rose(irq));
    cov_unmapped: cover property (pslverr);

endmodule // stc_sysref_cal

// ===== stc_pkg.sv
// Purpose: Shared constants for the SYSREF timing calibration block.
// Assumes: APB register access with 32-bit data, one register per aligned word.
// Notes: Register indices are kept as printed; byte address is four times the index.
package stc_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] IDX_ENABLE = 12'h2B0;
    localparam logic [ADDR_W-1:0] IDX_CONFIG = 12'h2B1;
    localparam logic [ADDR_W-1:0] IDX_RESULT = 12'h2B2;
    localparam logic [ADDR_W-1:0] IDX_ADJUST = 12'h2B5;
    localparam logic [ADDR_W-1:0] IDX_RAMP = 12'h2B8;
    localparam logic [ADDR_W-1:0] IDX_IRQ_STATUS = 12'h2BC;
    localparam logic [ADDR_W-1:0] IDX_IRQ_MASK = 12'h2BD;
    localparam logic [ADDR_W-1:0] ADDR_ENABLE = ADDR_W'(IDX_ENABLE * 4);
    localparam logic [ADDR_W-1:0] ADDR_CONFIG = ADDR_W'(IDX_CONFIG * 4);
    localparam logic [ADDR_W-1:0] ADDR_RESULT = ADDR_W'(IDX_RESULT * 4);
    localparam logic [ADDR_W-1:0] ADDR_ADJUST = ADDR_W'(IDX_ADJUST * 4);
    localparam logic [ADDR_W-1:0] ADDR_RAMP = ADDR_W'(IDX_RAMP * 4);
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = ADDR_W'(IDX_IRQ_STATUS * 4);
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = ADDR_W'(IDX_IRQ_MASK * 4);

    // ************************************************************
    // Reset values and fields
    // ************************************************************
    localparam logic [7:0] ENABLE_RST = 8'h00;
    localparam logic [7:0] CONFIG_RST = 8'h05;
    localparam logic [23:0] ADJUST_RST = 24'h000000;
    localparam logic [7:0] RAMP_RST = 8'h00;
    localparam logic [1:0] IRQ_RST = 2'h0;
    localparam int ENABLE_BIT = 0;
    localparam int AVG_LSB = 2;
    localparam int ACC_LSB = 0;
    localparam int DONE_BIT = 17;
    localparam int DELAY_W = 17;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_FAIL_BIT = 1;

    // ************************************************************
    // Calibration timing
    // ************************************************************
    localparam logic [15:0] MAX_PERIOD_0 = 16'd85;
    localparam logic [15:0] MAX_PERIOD_1 = 16'd1100;
    localparam logic [15:0] MAX_PERIOD_2 = 16'd5200;
    localparam logic [15:0] MAX_PERIOD_3 = 16'd21580;
    localparam int CAL_BOUND_AVG = 256;
    localparam int CAL_BOUND_STEP = 19;
    localparam int CAL_BOUND_EXP_OFS = 2;

    typedef enum logic [1:0] {
        STC_IDLE = 2'b00,
        STC_SYNC = 2'b01,
        STC_MEAS = 2'b10
    } stc_state_e;

endpackage

// ===== stc_cal_if.sv
// Purpose: Carries control and result between register logic and the measuring engine.
// Assumes: Single clock domain.
// Notes: Start and abort are one-cycle pulses; done and fail are one-cycle pulses.
`timescale 1ns/100ps
interface stc_cal_if;
    logic start;
    logic abort;
    logic [1:0] avg_code;
    logic [1:0] acc_code;
    logic [31:0] bound;
    logic done;
    logic fail;
    logic [16:0] delay;

    modport ctrl (output start, output abort, output avg_code, output acc_code, output bound,
                  input done, input fail, input delay);
    modport engine (input start, input abort, input avg_code, input acc_code, input bound,
                    output done, output fail, output delay);
endinterface

// ===== stc_cal_engine.sv
// Purpose: Measures the SYSREF edge phase against accumulation windows and averages it.
// Assumes: sysref is synchronous to clk.
// Notes: Fails on an overlong SYSREF period or when the duration bound runs out.
`timescale 1ns/100ps
module stc_cal_engine (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic sysref,
    stc_cal_if.engine cal
);

    stc_pkg::stc_state_e state;
    logic sysref_q;
    logic edge_seen;
    logic [7:0] phase_cnt;
    logic [7:0] phase_last;
    logic [15:0] period_cnt;
    logic [15:0] max_period;
    logic [31:0] time_cnt;
    logic [8:0] avg_cnt;
    logic [8:0] avg_last;
    logic [15:0] sum;
    logic [15:0] next_sum;
    logic [23:0] scaled;
    logic too_long;

    assign edge_seen = sysref && !sysref_q;
    assign phase_last = 8'((9'd4 << (2 * cal.acc_code)) - 9'd1);
    assign avg_last = 9'((10'd4 << (2 * cal.avg_code)) - 10'd1);
    assign next_sum = sum + {8'h00, phase_cnt};
    assign scaled = 24'({next_sum, 8'h00} >> (2 * (cal.avg_code + 2'd1)));
    assign too_long = (period_cnt >= max_period) || (time_cnt >= cal.bound);

    always_comb begin
        unique case (cal.acc_code)
            2'd0: max_period = stc_pkg::MAX_PERIOD_0;
            2'd1: max_period = stc_pkg::MAX_PERIOD_1;
            2'd2: max_period = stc_pkg::MAX_PERIOD_2;
            2'd3: max_period = stc_pkg::MAX_PERIOD_3;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sysref_q <= 1'b0;
        end else begin
            sysref_q <= sysref;
        end
    end

    // ************************************************************
    // Accumulation window phase, free running
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!reset_n || cal.start) begin
            phase_cnt <= 8'h00;
        end else if (phase_cnt >= phase_last) begin
            phase_cnt <= 8'h00;
        end else begin
            phase_cnt <= phase_cnt + 8'h01;
        end
    end

    // ************************************************************
    // Sequence control
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state <= stc_pkg::STC_IDLE;
            period_cnt <= 16'h0000;
            time_cnt <= 32'h00000000;
            avg_cnt <= 9'h000;
            sum <= 16'h0000;
            cal.done <= 1'b0;
            cal.fail <= 1'b0;
            cal.delay <= 17'h00000;
        end else begin
            cal.done <= 1'b0;
            cal.fail <= 1'b0;
            if (cal.abort) begin
                state <= stc_pkg::STC_IDLE;
            end else if (cal.start) begin
                state <= stc_pkg::STC_SYNC;
                period_cnt <= 16'h0000;
                time_cnt <= 32'h00000000;
                avg_cnt <= 9'h000;
                sum <= 16'h0000;
            end else begin
                unique case (state)
                    stc_pkg::STC_IDLE: begin
                    end
                    stc_pkg::STC_SYNC, stc_pkg::STC_MEAS: begin
                        time_cnt <= time_cnt + 32'h00000001;
                        period_cnt <= edge_seen ? 16'h0000 : period_cnt + 16'h0001;
                        if (too_long) begin
                            cal.fail <= 1'b1;
                            state <= stc_pkg::STC_IDLE;
                        end else if (edge_seen && state == stc_pkg::STC_SYNC) begin
                            state <= stc_pkg::STC_MEAS;
                        end else if (edge_seen) begin
                            sum <= next_sum;
                            avg_cnt <= avg_cnt + 9'h001;
                            if (avg_cnt == avg_last) begin
                                cal.delay <= {1'b0, scaled[15:0]};
                                cal.done <= 1'b1;
                                state <= stc_pkg::STC_IDLE;
                            end
                        end
                    end
                    default: state <= stc_pkg::STC_IDLE;
                endcase
            end
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    chk_fail_cause: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(cal.fail) |-> $past(too_long))
        else $error("fail pulse without an overlong period or timeout");
    chk_bound_kept: assert property (@(posedge clk) disable iff (!reset_n)
        state != stc_pkg::STC_IDLE |-> time_cnt <= cal.bound)
        else $error("calibration ran past its duration bound");
    cov_done: cover property (@(posedge clk) disable iff (!reset_n) cal.done);
    cov_fail: cover property (@(posedge clk) disable iff (!reset_n) cal.fail);

endmodule // stc_cal_engine

// ===== stc_sysref_source.sv
// Purpose: Periodic SYSREF source that stands at the far side of the calibration block.
// Assumes: One clock; each SYSREF pulse is one cycle wide and synchronous to clk.
// Notes: The bench sets the period and may make it overlong on purpose.
`timescale 1ns/100ps
module stc_sysref_source (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic run,
    input wire logic [15:0] period,
    output logic sysref
);
    logic [15:0] count;

    // The period follows the bench, so it stays inside the limit of the chosen length unless a fault is wanted.
    always_ff @(posedge clk) begin
        if (!reset_n || !run) begin
            count <= 16'h0000;
            sysref <= 1'b0;
        end else if (count >= period - 16'h0001) begin
            count <= 16'h0000;
            sysref <= 1'b1;
        end else begin
            count <= count + 16'h0001;
            sysref <= 1'b0;
        end
    end
endmodule // stc_sysref_source

// ===== test_sysref_timing_calibration.sv
// Purpose: Self-checking bench for SYSREF timing calibration over APB.
// Assumes: A shortened duration bound (base 16) keeps every run brief yet leaves room for the shortest setting.
// Notes: Timing windows allow for the edge detector and the wait for the first SYSREF edge.
`timescale 1ns/100ps
module test_sysref_timing_calibration;
    localparam int BASE = 16;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic run = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [15:0] period = 16'h0014;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sysref;
    logic irq;
    logic [16:0] aperture_delay;
    logic [16:0] held;
    logic [31:0] r;
    logic e;
    int failures = 0;
    int n_checks = 0;
    int cycles = 0;

    always #25 clk = ~clk;

    stc_sysref_cal #(.CAL_BOUND_BASE(BASE)) dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sysref(sysref), .aperture_delay(aperture_delay), .irq(irq));
    stc_sysref_source src (.clk(clk), .reset_n(reset_n), .run(run), .period(period), .sysref(sysref));

    // ************************************************************
    // Tasks
    // ************************************************************
    task conclude;
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        n_checks++;
        if (got !== ex) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, ex, got);
        end
    endtask

    // The request is held until pready is sampled high, or for at most 16 more cycles, counted as a failure; then it is released.
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q, output logic er);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 16) begin
            @(posedge clk);
            n++;
        end
        if (n == 16) failures++;
        q = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic er;
        xfer(1'b1, a, d, q, er);
    endtask

    task rd(input logic [11:0] a, output logic [31:0] q);
        xfer(1'b0, a, 32'h00000000, q, e);
    endtask

    task settle;
        repeat (3) @(posedge clk);
        #1;
    endtask

    task run_cal(input logic [1:0] avg, input logic [1:0] acc, input int per, input logic fail);
        int n;
        int lim;
        int na;
        n = 0;
        na = 1 << (2 * avg + 2);
        lim = BASE << (2 * (avg + acc + 2));
        wr(stc_pkg::ADDR_ENABLE, 32'h0);
        wr(stc_pkg::ADDR_IRQ_STATUS, 32'h3);
        wr(stc_pkg::ADDR_CONFIG, {28'h0, avg, acc});
        period <= 16'(per);
        wr(stc_pkg::ADDR_ENABLE, 32'h1);
        while (irq !== 1'b1 && n < lim + 8) begin
            @(posedge clk);
            n++;
        end
        rd(stc_pkg::ADDR_IRQ_STATUS, r);
        chk("irq_status", fail ? 32'h2 : 32'h1, r);
        chk("cal_bound", 1, 32'(n <= lim));
        rd(stc_pkg::ADDR_RESULT, r);
        chk("done_bit", 32'(!fail), 32'(r[17]));
        if (!fail) begin
            chk("cal_cycles", 1, 32'(n >= na * per - 4 && n <= (na + 1) * per + 8));
            chk("delay_field", 1, 32'(r[16] == 1'b0 && r[15:8] < (1 << (2 * acc + 2))));
            chk("applied_delay", r & 32'h1FFFF, 32'(aperture_delay));
        end
        $display("test calibration avg %0d acc %0d period %0d done", avg, acc, per);
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            conclude();
        end
    end

    initial begin
        logic [11:0] ra [6];
        logic [31:0] rv [6];
        ra = '{stc_pkg::ADDR_ENABLE, stc_pkg::ADDR_CONFIG, stc_pkg::ADDR_ADJUST, stc_pkg::ADDR_RAMP,
               stc_pkg::ADDR_IRQ_STATUS, stc_pkg::ADDR_IRQ_MASK};
        rv = '{32'h00, 32'h05, 32'h00, 32'h00, 32'h00, 32'h00};
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 6; i++) begin
            rd(ra[i], r);
            chk("reset_value", rv[i], r);
        end
        chk("reset_delay", 32'h0, 32'(aperture_delay));
        rd(12'hAE4, r);
        chk("unmapped_err", 32'h1, 32'(e));
        wr(stc_pkg::ADDR_RAMP, 32'h3);
        rd(stc_pkg::ADDR_RAMP, r);
        chk("ramp", 32'h3, r);
        wr(stc_pkg::ADDR_ADJUST, 32'h1ABCD);
        settle();
        chk("manual_delay", 32'h1ABCD, 32'(aperture_delay));
        $display("test registers done");
        wr(stc_pkg::ADDR_IRQ_MASK, 32'h3);
        run <= 1'b1;
        run_cal(2'h0, 2'h1, 20, 1'b0);
        held = aperture_delay;
        wr(stc_pkg::ADDR_RESULT, 32'hFFFFFFFF);
        rd(stc_pkg::ADDR_RESULT, r);
        chk("result_ro", 32'(held) | 32'h20000, r);
        wr(stc_pkg::ADDR_IRQ_STATUS, 32'h3);
        wr(stc_pkg::ADDR_ENABLE, 32'h1);
        repeat (200) @(posedge clk);
        rd(stc_pkg::ADDR_IRQ_STATUS, r);
        chk("no_restart", 32'h0, r);
        wr(stc_pkg::ADDR_ADJUST, 32'h00055);
        settle();
        chk("manual_ignored", 32'(held), 32'(aperture_delay));
        $display("test hold while enabled done");
        wr(stc_pkg::ADDR_IRQ_MASK, 32'h0);
        wr(stc_pkg::ADDR_ENABLE, 32'h0);
        wr(stc_pkg::ADDR_ENABLE, 32'h1);
        rd(stc_pkg::ADDR_RESULT, r);
        chk("done_cleared", 32'h0, 32'(r[17]));
        repeat (200) @(posedge clk);
        chk("irq_masked", 32'h0, 32'(irq));
        rd(stc_pkg::ADDR_IRQ_STATUS, r);
        chk("restart_status", 32'h1, r);
        wr(stc_pkg::ADDR_IRQ_MASK, 32'h1);
        settle();
        chk("irq_unmasked", 32'h1, 32'(irq));
        wr(stc_pkg::ADDR_IRQ_STATUS, 32'h1);
        settle();
        chk("irq_cleared", 32'h0, 32'(irq));
        wr(stc_pkg::ADDR_ENABLE, 32'h0);
        settle();
        chk("manual_again", 32'h00055, 32'(aperture_delay));
        rd(stc_pkg::ADDR_RESULT, r);
        chk("done_disabled", 32'h0, 32'(r[17]));
        $display("test interrupt and disable done");
        wr(stc_pkg::ADDR_IRQ_MASK, 32'h3);
        for (int i = 0; i < 4; i++) begin
            run_cal(2'(i), 2'(i), 20, 1'b0);
        end
        run_cal(2'h0, 2'h0, 200, 1'b1);
        conclude();
    end
endmodule // test_sysref_timing_calibration
